// ---- rir_exec.sv ----
// Purpose: executes interrupt return and the seven rotate operations
// Assumes: operand byte is valid during the cycle op_valid_in is high
// Notes: all results are registered and visible on the next cycle
`timescale 1ns/1ps
`include "rir_cfg.svh"

module rir_exec
  import rir_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic op_valid_in,
  input wire rir_op_type op_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [12:0] stack_top_in,
  input wire logic irq_pending_in,
  input wire logic irq_en_clear_in,
  output logic [7:0] acc_out,
  output logic cy_out,
  output logic global_irq_enable_out,
  output logic [12:0] pc_out,
  output logic pc_load_out,
  output logic stack_pop_out,
  output logic irq_take_out,
  output logic mem_we_out,
  output logic [7:0] mem_wdata_out
);

  rir_state_type state_reg;
  rir_state_type state_next;

  // ****************************************
  // rotate helpers
  // ****************************************
  // both return {carry_out, byte}; the caller picks the fill bit
  function automatic logic [8:0] rot_left(input logic [7:0] d, input logic fill);
    logic [7:0] res;
    logic cout;
    res = {d[6:0], fill};
    cout = d[`RIR_MSB];
    rot_left = {cout, res};
  endfunction : rot_left

  function automatic logic [8:0] rot_right(input logic [7:0] d, input logic fill);
    logic [7:0] res;
    logic cout;
    res = {fill, d[7:1]};
    cout = d[`RIR_LSB];
    rot_right = {cout, res};
  endfunction : rot_right

  // ****************************************
  // operation decode
  // ****************************************
  // only the rotate codes reach the shared datapath
  function automatic logic is_rotate(input rir_op_type op);
    case (op)
      RIR_OP_ROT_L,
      RIR_OP_ROT_L_ACC,
      RIR_OP_ROT_L_CY,
      RIR_OP_ROT_L_CY_ACC,
      RIR_OP_ROT_R,
      RIR_OP_ROT_R_ACC,
      RIR_OP_ROT_R_CY: begin
        is_rotate = 1'b1;
      end
      default: begin
        is_rotate = 1'b0;
      end
    endcase
  endfunction : is_rotate

  // the accumulator forms leave the memory byte untouched
  function automatic logic writes_memory(input rir_op_type op);
    case (op)
      RIR_OP_ROT_L,
      RIR_OP_ROT_L_CY,
      RIR_OP_ROT_R,
      RIR_OP_ROT_R_CY: begin
        writes_memory = 1'b1;
      end
      default: begin
        writes_memory = 1'b0;
      end
    endcase
  endfunction : writes_memory

  // ****************************************
  // per-operation result
  // ****************************************
  // returns {carry_next, byte}; the plain forms hand back the old carry
  function automatic logic [8:0] rot_result(input rir_op_type op, input logic [7:0] d, input logic c);
    logic [8:0] r;
    r = 9'h000;
    case (op)
      RIR_OP_ROT_L: begin
        r = rot_left(d, d[`RIR_MSB]);
        r[8] = c;
      end
      RIR_OP_ROT_L_ACC: begin
        r = rot_left(d, d[`RIR_MSB]);
        r[8] = c;
      end
      RIR_OP_ROT_L_CY: begin
        r = rot_left(d, c);
      end
      RIR_OP_ROT_L_CY_ACC: begin
        r = rot_left(d, c);
      end
      RIR_OP_ROT_R: begin
        r = rot_right(d, d[`RIR_LSB]);
        r[8] = c;
      end
      RIR_OP_ROT_R_ACC: begin
        r = rot_right(d, d[`RIR_LSB]);
        r[8] = c;
      end
      RIR_OP_ROT_R_CY: begin
        r = rot_right(d, c);
      end
      default: begin
        r = {c, d};
      end
    endcase
    rot_result = r;
  endfunction : rot_result

  // ****************************************
  // interrupt return
  // ****************************************
  // status flags pass through untouched
  function automatic rir_state_type irq_exit_next(input rir_state_type s, input logic [12:0] ret_pc,
    input logic pend);
    rir_state_type n;
    n = s;
    n.pc = ret_pc;
    n.pc_load = 1'b1;
    n.stack_pop = 1'b1;
    n.irq_en = `RIR_IRQ_EN_SET;
    n.irq_take = pend;
    irq_exit_next = n;
  endfunction : irq_exit_next

  // ****************************************
  // reset values
  // ****************************************
  function automatic rir_state_type reset_state();
    rir_state_type z;
    z.acc = `RIR_ACC_RESET;
    z.cy = `RIR_CY_RESET;
    z.irq_en = `RIR_IRQ_EN_RESET;
    z.pc = `RIR_PC_RESET;
    z.mem_we = 1'b0;
    z.mem_wdata = 8'h00;
    z.pc_load = 1'b0;
    z.irq_take = 1'b0;
    z.stack_pop = 1'b0;
    reset_state = z;
  endfunction : reset_state

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [8:0] r;
    r = 9'h000;
    state_next = state_reg;
    // pulses last one cycle unless an op raises them again
    state_next.mem_we = 1'b0;
    state_next.pc_load = 1'b0;
    state_next.irq_take = 1'b0;
    state_next.stack_pop = 1'b0;
    // a return in the same cycle overrides this clear
    if (irq_en_clear_in) begin
      state_next.irq_en = 1'b0;
    end
    if (op_valid_in) begin
      if (op_in == RIR_OP_IRQ_EXIT) begin
        state_next = irq_exit_next(state_next, stack_top_in, irq_pending_in);
      end else if (is_rotate(op_in)) begin
        r = rot_result(op_in, mem_rdata_in, state_reg.cy);
        state_next.cy = r[8];
        if (writes_memory(op_in)) begin
          state_next.mem_wdata = r[7:0];
          state_next.mem_we = 1'b1;
        end else begin
          state_next.acc = r[7:0];
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_reg <= reset_state();
    end else begin
      state_reg <= state_next;
    end
  end

  assign acc_out = state_reg.acc;
  assign cy_out = state_reg.cy;
  assign global_irq_enable_out = state_reg.irq_en;
  assign pc_out = state_reg.pc;
  assign pc_load_out = state_reg.pc_load;
  assign stack_pop_out = state_reg.stack_pop;
  assign irq_take_out = state_reg.irq_take;
  assign mem_we_out = state_reg.mem_we;
  assign mem_wdata_out = state_reg.mem_wdata;

endmodule : rir_exec

// ---- rir_cfg.svh ----
// Purpose: constants for the rotate and interrupt-return execution block
// Assumes: 8-bit data path, 13-bit program counter
// Notes: opcode encodings are local to this block
`ifndef RIR_CFG_SVH
`define RIR_CFG_SVH

`define RIR_DATA_W 8
`define RIR_PC_W 13
`define RIR_MSB 7
`define RIR_LSB 0
`define RIR_IRQ_EN_SET 1'b1
`define RIR_ACC_RESET 8'h00
`define RIR_CY_RESET 1'b0
`define RIR_IRQ_EN_RESET 1'b0
`define RIR_PC_RESET 13'h0000

`endif

// ---- rir_pkg.sv ----
// Purpose: types for the rotate and interrupt-return execution block
// Assumes: decoder presents one operation code per instruction cycle
// Notes: op codes carry no fixed encoding
package rir_pkg;

  typedef enum logic [3:0] {
    RIR_OP_NONE,
    RIR_OP_IRQ_EXIT,
    RIR_OP_ROT_L,
    RIR_OP_ROT_L_ACC,
    RIR_OP_ROT_L_CY,
    RIR_OP_ROT_L_CY_ACC,
    RIR_OP_ROT_R,
    RIR_OP_ROT_R_ACC,
    RIR_OP_ROT_R_CY
  } rir_op_type;

  typedef struct packed {
    logic [7:0] acc;
    logic cy;
    logic irq_en;
    logic [12:0] pc;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic pc_load;
    logic irq_take;
    logic stack_pop;
  } rir_state_type;

endpackage : rir_pkg

// ---- rir_exec_props.sv ----
// Purpose: port checks for rir_exec
// Assumes: one op taken per edge with op_valid_in high
// Notes: bound to every rir_exec instance
`timescale 1ns/1ps
module rir_exec_props
  import rir_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic op_valid_in,
  input wire logic irq_pending_in,
  input wire rir_op_type op_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic [12:0] stack_top_in,
  input wire logic [12:0] pc_out,
  input wire logic cy_out,
  input wire logic global_irq_enable_out,
  input wire logic pc_load_out,
  input wire logic stack_pop_out,
  input wire logic irq_take_out,
  input wire logic mem_we_out
);
  logic [7:0] rl, rr;
  logic [8:0] lc, rc;
  assign rl = {mem_rdata_in[6:0], mem_rdata_in[7]};
  assign rr = {mem_rdata_in[0], mem_rdata_in[7:1]};
  // carry ops seen as one nine-bit ring, carry on top
  assign lc = {mem_rdata_in, cy_out};
  assign rc = {mem_rdata_in[0], cy_out, mem_rdata_in[7:1]};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence tk(rir_op_type o);
    op_valid_in && op_in == o;
  endsequence
  exit_pc_a: assert property (tk(RIR_OP_IRQ_EXIT) |=> pc_load_out && stack_pop_out && global_irq_enable_out
    && pc_out == $past(stack_top_in)) else $error("bad exit");
  exit_flags_a: assert property (tk(RIR_OP_IRQ_EXIT) |=> $stable(cy_out) && $stable(acc_out) && !mem_we_out)
    else $error("exit changed flags");
  exit_take_a: assert property (tk(RIR_OP_IRQ_EXIT) |=> irq_take_out == $past(irq_pending_in))
    else $error("bad take");
  rl_mem_a: assert property (tk(RIR_OP_ROT_L) |=> mem_we_out && mem_wdata_out == $past(rl) && $stable(cy_out))
    else $error("bad rl");
  rl_acc_a: assert property (tk(RIR_OP_ROT_L_ACC) |=> !mem_we_out && acc_out == $past(rl) && $stable(cy_out))
    else $error("bad rla");
  rlc_mem_a: assert property (tk(RIR_OP_ROT_L_CY) |=> mem_we_out && {cy_out, mem_wdata_out} == $past(lc))
    else $error("bad rlc");
  rlc_acc_a: assert property (tk(RIR_OP_ROT_L_CY_ACC) |=> !mem_we_out && {cy_out, acc_out} == $past(lc))
    else $error("bad rotate_left_via_cy_to_accum");
  rr_mem_a: assert property (tk(RIR_OP_ROT_R) |=> mem_we_out && mem_wdata_out == $past(rr) && $stable(cy_out))
    else $error("bad rr");
  rr_acc_a: assert property (tk(RIR_OP_ROT_R_ACC) |=> !mem_we_out && acc_out == $past(rr) && $stable(cy_out))
    else $error("bad rra");
  rrc_mem_a: assert property (tk(RIR_OP_ROT_R_CY) |=> mem_we_out && {cy_out, mem_wdata_out} == $past(rc))
    else $error("bad rrc");
endmodule : rir_exec_props
bind rir_exec rir_exec_props u_props(.ref_clk_in, .resetn_in, .op_valid_in, .irq_pending_in, .op_in, .mem_rdata_in,
  .acc_out, .mem_wdata_out, .stack_top_in, .pc_out, .cy_out, .global_irq_enable_out, .pc_load_out, .stack_pop_out,
  .irq_take_out, .mem_we_out);

// ---- rir_mem_model.sv ----
// Purpose: operand byte of data memory
// Assumes: bench preloads the byte before each op
// Notes: preload wins over a write-back in the same cycle
`timescale 1ns/1ps
module rir_mem_model (
  input wire logic ref_clk_in,
  input wire logic we_in,
  input wire logic [7:0] wd_in,
  input wire logic poke_in,
  input wire logic [7:0] pd_in,
  output logic [7:0] rd_out
);
  always_ff @(posedge ref_clk_in) begin
    if (poke_in) rd_out <= pd_in;
    else if (we_in) rd_out <= wd_in;
  end
endmodule : rir_mem_model

// ---- rir_exec_tb_top.sv ----
// Purpose: self-checking bench for rir_exec
// Assumes: inputs change on the falling edge
// Notes: expected values worked out locally
`timescale 1ns/1ps
module rir_exec_tb_top
  import rir_pkg::*;
;
  logic ref_clk_in = 0, resetn_in = 0, op_valid_in = 0, irq_pending_in = 0, irq_en_clear_in = 0, poke = 0;
  rir_op_type op_in = RIR_OP_NONE;
  logic [7:0] mem_rdata_in, acc_out, mem_wdata_out, pd = 8'h00;
  logic [12:0] stack_top_in = 13'h0000, pc_out;
  logic cy_out, global_irq_enable_out, pc_load_out, stack_pop_out, irq_take_out, mem_we_out;
  int error_cnt = 0, tests_run = 0;
  always #25 ref_clk_in = ~ref_clk_in;
  rir_exec dut(.ref_clk_in, .resetn_in, .op_valid_in, .op_in, .mem_rdata_in, .stack_top_in, .irq_pending_in,
    .irq_en_clear_in, .acc_out, .cy_out, .global_irq_enable_out, .pc_out, .pc_load_out, .stack_pop_out,
    .irq_take_out, .mem_we_out, .mem_wdata_out);
  rir_mem_model mem(.ref_clk_in, .we_in(mem_we_out), .wd_in(mem_wdata_out), .poke_in(poke), .pd_in(pd),
    .rd_out(mem_rdata_in));
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [8:0] rot(input int o, input logic [7:0] d, input logic c);
    case (o)
      2, 3: rot = {c, d[6:0], d[7]};
      4, 5: rot = {d, c};
      6, 7: rot = {c, d[0], d[7:1]};
      default: rot = {d[0], c, d[7:1]};
    endcase
  endfunction : rot
  // even codes write memory, odd ones the accumulator
  task automatic t_rot;
    logic [8:0] e;
    logic [7:0] a;
    for (int i = 2; i < 9; i++) begin
      pd = 8'h81 + 8'(i);
      poke = 1;
      @(negedge ref_clk_in);
      poke = 0;
      chk(13'({mem_we_out, pc_load_out}), 13'h0000);
      a = acc_out;
      e = rot(i, pd, cy_out);
      op_in = rir_op_type'(i);
      op_valid_in = 1;
      @(negedge ref_clk_in);
      op_valid_in = 0;
      chk(13'(mem_we_out), 13'(!i[0]));
      chk(13'(acc_out), 13'(i[0] ? e[7:0] : a));
      chk(13'(cy_out), 13'(e[8]));
      if (!i[0]) chk(13'(mem_wdata_out), 13'(e[7:0]));
    end
    $display("rotate test done");
  endtask : t_rot
  task automatic t_exit;
    for (int j = 0; j < 2; j++) begin
      irq_en_clear_in = 1;
      @(negedge ref_clk_in);
      irq_en_clear_in = 0;
      chk(13'(global_irq_enable_out), 13'h0000);
      stack_top_in = 13'h0123 + 13'(j);
      irq_pending_in = !j;
      op_in = RIR_OP_IRQ_EXIT;
      op_valid_in = 1;
      @(negedge ref_clk_in);
      op_valid_in = 0;
      chk(pc_out, 13'h0123 + 13'(j));
      chk(13'({pc_load_out, stack_pop_out, global_irq_enable_out}), 13'h0007);
      chk(13'(irq_take_out), 13'(!j));
    end
    // a clear and a return in one cycle: the return wins
    irq_en_clear_in = 1;
    @(negedge ref_clk_in);
    chk(13'(global_irq_enable_out), 13'h0000);
    op_in = RIR_OP_IRQ_EXIT;
    op_valid_in = 1;
    @(negedge ref_clk_in);
    irq_en_clear_in = 0;
    op_valid_in = 0;
    chk(13'(global_irq_enable_out), 13'h0001);
    $display("exit test done");
  endtask : t_exit
  task automatic finish_test;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(negedge ref_clk_in);
    resetn_in = 1;
    chk(13'({acc_out, cy_out, global_irq_enable_out, mem_we_out}), 13'h0000);
    t_rot;
    t_exit;
    finish_test;
  end
  // a run is about 25 cycles, so 20 us means a hang
  initial begin
    #20us;
    error_cnt++;
    finish_test;
  end
endmodule : rir_exec_tb_top
